// ### feu_core.v
/*
 * erase-block, erase-sector and unsecure command sequencer with an apb
 * register slave. assumes one 10 MHz clock, the array erase/verify is
 * modelled by timers and a fault-injection register.
 *
 * holds: reset release, apb decode, parameter word capture, launch
 * checks, the erase / verify sequencer, status flags, config registers
 * and the registered apb answer.
 *
 * assumes: the apb master holds psel, paddr, pwrite and pwdata steady
 * through the access phase, the host stays off the bus while a command
 * runs, and the fault register stands in for the array's verify result.
 */
// The APB slave port and the address map were left to the implementer.
`include "feu_regs.vh"

module feu_core (
  input  wire        clk_in,      // 10 MHz clock
  input  wire        arst_n_in,   // async reset, active low
  input  wire        psel_in,     // apb select
  input  wire        penable_in,  // apb enable
  input  wire        pwrite_in,   // apb direction
  input  wire [11:0] paddr_in,    // apb byte address
  input  wire [31:0] pwdata_in,   // apb write data
  output reg  [31:0] prdata_out,  // apb read data
  output reg         pready_out,  // apb ready
  output reg         pslverr_out, // apb error
  output reg         busy_out,    // sequencer running
  output reg         secure_out   // security state
);
  // ================================================================
  // states
  localparam ST_IDLE  = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_VERI  = 2'h2;
  localparam ST_DONE  = 2'h3;
  // idle waits for a launch; erase and verify each run the down counter;
  // done lasts one cycle so the result flags post exactly once

  // erase and verify lengths in clocks, cut to the counter width on load
  localparam [31:0] ERASE_CYC  = `FEU_ERASE_CYC;
  localparam [31:0] VERIFY_CYC = `FEU_VERIFY_CYC;

  // reset release, sequencer state and timer
  reg        rs1_q;
  reg        rst_n_q;
  reg [1:0]  st_q;
  reg [1:0]  st_d;
  reg [15:0] cnt_q;
  reg [7:0]  cmd_q;
  // status flags
  reg        done_q;
  reg        acc_q;
  reg        pv_q;
  reg        ve_q;
  reg        vf_q;
  // config registers
  reg [2:0]  ix_q;
  reg [2:0]  mode_q;
  reg [2:0]  prot_q;
  reg [1:0]  fault_q;
  // captured parameters and apb bookkeeping
  reg [7:0]  p0hi_q;
  reg [15:0] p1_q;
  reg        rdpend_q;
  wire [15:0] mem_rd;

  // ================================================================
  // reset release through two flops
  // async assert, sync release: no flop leaves reset mid-cycle;
  // the first flop is read by the second only
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rs1_q   <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rs1_q   <= 1'b1;
      rst_n_q <= rs1_q;
    end
  end

  // apb decode; writes only when the access phase completes, that is at
  // the edge that samples pready high; full 12-bit compares so that an
  // alias of a register cannot hide an address fault
  wire acc_ph = psel_in & penable_in;
  wire wr     = acc_ph & pwrite_in & pready_out;
  wire hit_st = (paddr_in == `FEU_OFF_STAT);
  wire hit_ix = (paddr_in == `FEU_OFF_INDEX);
  wire hit_pa = (paddr_in == `FEU_OFF_PARAM);
  wire hit_md = (paddr_in == `FEU_OFF_MODE);
  wire hit_pr = (paddr_in == `FEU_OFF_PROT);
  wire hit_sc = (paddr_in == `FEU_OFF_SEC);
  wire hit_fl = (paddr_in == `FEU_OFF_FAULT);
  wire mapped = hit_st | hit_ix | hit_pa | hit_md | hit_pr | hit_sc | hit_fl;

  // writes during a running command are dropped to protect the sequence
  wire wr_ok  = wr & done_q;
  wire launch = wr_ok & hit_st & pwdata_in[`FEU_STAT_DONE_BIT];
  wire pw_wr  = wr_ok & hit_pa;

  // ================================================================
  // parameter word store, read back through the index register; one
  // shared index for both ports, traded against a wider register map
  feu_param_mem feu_param_mem_inst (
    .clk_in     (clk_in),
    .wr_en_in   (pw_wr),
    .wr_idx_in  (ix_q),
    .wr_dat_in  (pwdata_in[15:0]),
    .rd_idx_in  (ix_q),
    .rd_dat_out (mem_rd)
  );

  // ================================================================
  // capture word 0 high byte and word 1 alongside the memory, so the
  // launch checks see them at once instead of through a read cycle
  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cmd_q  <= 8'h00;
      p0hi_q <= 8'h00;
      p1_q   <= 16'h0000;
    end else if (pw_wr && ix_q == 3'h0) begin
      cmd_q  <= pwdata_in[15:8];
      p0hi_q <= pwdata_in[7:0];
    end else if (pw_wr && ix_q == 3'h1) begin
      p1_q   <= pwdata_in[15:0];
    end
  end

  // ================================================================
  // launch checks, mode bit n enables command n
  wire is_blk = (cmd_q == `FEU_CMD_BLK);
  wire is_sec = (cmd_q == `FEU_CMD_SEC);
  wire is_uns = (cmd_q == `FEU_CMD_UNS);
  wire is_pf  = (p0hi_q == `FEU_PF_HI);
  wire is_ee  = (p0hi_q == `FEU_EE_HI);

  // the index must match the parameter count of the command
  wire bad_ix = ((is_blk | is_sec) & (ix_q != `FEU_IX_BLK))
              | (is_uns & (ix_q != `FEU_IX_UNS));

  // operating mode: one enable bit per command
  wire bad_md = (is_blk & ~mode_q[0]) | (is_sec & ~mode_q[1])
              | (is_uns & ~mode_q[2]);

  // only the two known block high bytes are valid targets
  wire bad_ad = (is_blk & ~(is_pf | is_ee)) | (is_sec & ~is_pf);
  // alignment: a phrase for program space, a word for eeprom
  wire bad_al = (is_blk & is_pf & (p1_q[2:0] != 3'h0))
              | (is_blk & is_ee & p1_q[0])
              | (is_sec & (p1_q[2:0] != 3'h0));

  // prot bit 0 covers a program sector, bit 1 program block, bit 2 eeprom;
  // a protected program block also protects every sector inside it
  wire sec_pr = prot_q[0] & (p1_q[15:`FEU_SECT_BITS] == 7'h00);
  wire bad_pv = (is_blk & is_pf & (prot_q[0] | prot_q[1]))
              | (is_blk & is_ee & prot_q[2])
              | (is_sec & (sec_pr | prot_q[1]))
              | (is_uns & (prot_q != 3'h0));

  // unknown codes are refused with an access error; an access error
  // masks a protection violation so that only one cause is reported
  wire bad_cmd = ~(is_blk | is_sec | is_uns);
  wire acc_err = bad_ix | bad_md | bad_ad | bad_al | bad_cmd;

  // ================================================================
  // sequencer: erase, then verify, then complete
  // limitation: erase and verify are timers here, no array is touched
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:  if (launch && !acc_err && !bad_pv) st_d = ST_ERASE;
      ST_ERASE: if (cnt_q == 16'h0000) st_d = ST_VERI;
      ST_VERI:  if (cnt_q == 16'h0000) st_d = ST_DONE;
      ST_DONE:  st_d = ST_IDLE;
      default:  st_d = ST_IDLE;
    endcase
  end

  // state register and down counter, loaded on entry to erase and to verify and
  // held at zero once run out
  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q  <= ST_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      if (st_q == ST_IDLE && st_d == ST_ERASE) begin
        cnt_q <= ERASE_CYC[15:0] - 16'h0001;
      end else if (st_q == ST_ERASE && st_d == ST_VERI) begin
        cnt_q <= VERIFY_CYC[15:0] - 16'h0001;
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // ================================================================
  // status flags; a launch clears old errors, w1c on acc / pv
  // the errors stay until cleared or relaunched; a security write can
  // only raise security, so release needs a successful unsecure command
  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      done_q     <= 1'b1;
      acc_q      <= 1'b0;
      pv_q       <= 1'b0;
      ve_q       <= 1'b0;
      vf_q       <= 1'b0;
      secure_out <= `FEU_SEC_RST;
    end else begin
      if (launch) begin
        done_q <= ~(~acc_err & ~bad_pv);      // failed launch stays complete
        acc_q  <= acc_err;
        pv_q   <= ~acc_err & bad_pv;
        ve_q   <= 1'b0;
        vf_q   <= 1'b0;
      end else begin
        if (wr_ok && hit_st && pwdata_in[`FEU_STAT_ACC_BIT]) begin
          acc_q <= 1'b0;
        end
        if (wr_ok && hit_st && pwdata_in[`FEU_STAT_PV_BIT]) begin
          pv_q <= 1'b0;
        end
        if (st_q == ST_DONE) begin
          done_q <= 1'b1;
          ve_q   <= fault_q[0] | fault_q[1];
          vf_q   <= fault_q[1];
          if (is_uns && fault_q == 2'h0) begin
            secure_out <= 1'b0;
          end                                 // failure leaves it
        end
      end
      if (wr_ok && hit_sc && pwdata_in[0]) begin
        secure_out <= 1'b1;
      end
    end
  end

  // ================================================================
  // config registers: index, mode enables, protection, verify fault
  // mode and protection are not locked here; gating them is left outside
  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ix_q    <= 3'h0;
      mode_q  <= `FEU_MODE_RST;
      prot_q  <= `FEU_PROT_RST;
      fault_q <= 2'h0;
    end else if (wr_ok) begin
      if (hit_ix) ix_q    <= pwdata_in[2:0];
      if (hit_md) mode_q  <= pwdata_in[2:0];
      if (hit_pr) prot_q  <= pwdata_in[2:0];
      if (hit_fl) fault_q <= pwdata_in[1:0];
    end
  end

  // ================================================================
  // apb answer: two wait states so param reads see registered memory
  // pready is a one-cycle pulse; rdpend_q blocks a second pulse within
  // the same access; unmapped addresses read zero with pslverr
  // the extra cycle is the price of keeping prdata a flop output
  always @(posedge clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdpend_q    <= 1'b0;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
      busy_out    <= 1'b0;
    end else begin
      busy_out <= (st_d != ST_IDLE);
      rdpend_q <= acc_ph & ~pready_out & ~rdpend_q;
      if (rdpend_q && !pready_out) begin
        pready_out  <= 1'b1;
        pslverr_out <= ~mapped;
        prdata_out  <= 32'h00000000;
        if (hit_st) prdata_out <= {24'h000000, done_q, 1'b0, acc_q, pv_q, 2'h0, ve_q, vf_q};
        if (hit_ix) prdata_out <= {29'h00000000, ix_q};
        if (hit_pa) prdata_out <= {16'h0000, mem_rd};
        if (hit_md) prdata_out <= {29'h00000000, mode_q};
        if (hit_pr) prdata_out <= {29'h00000000, prot_q};
        if (hit_sc) prdata_out <= {31'h00000000, secure_out};
        if (hit_fl) prdata_out <= {30'h00000000, fault_q};
      end else begin
        pready_out  <= 1'b0;
        pslverr_out <= 1'b0;
      end
    end
  end
endmodule

// ### feu_core_properties.sv
/* port checker for feu_core.
   assumes one clock and the bind below. */
module feu_props (
  input wire        clk_in,      // clock
  input wire        arst_n_in,   // reset
  input wire        psel_in,     // select
  input wire        penable_in,  // enable
  input wire        pwrite_in,   // direction
  input wire [11:0] paddr_in,    // address
  input wire [31:0] pwdata_in,   // wdata
  input wire [31:0] prdata_out,  // rdata
  input wire        pready_out,  // ready
  input wire        pslverr_out, // error
  input wire        busy_out,    // running
  input wire        secure_out   // secured
);
  // ==========
  // launch strobe, sampled through $past
  wire lnch = psel_in & penable_in & pready_out & pwrite_in & (paddr_in == 12'h000)
            & pwdata_in[7];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access");
  ready_bound_a: assert property (psel_in && penable_in && !$past(penable_in) |-> ##[0:2] pready_out)
    else $error("access not answered");
  err_data_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
    else $error("error without ready or with data");
  busy_min_a: assert property ($rose(busy_out) |-> ##200 busy_out)
    else $error("erase ended early");
  busy_max_a: assert property ($rose(busy_out) |-> ##[240:260] !busy_out)
    else $error("erase never ended");
  stat_busy_a: assert property (pready_out && !pwrite_in && paddr_in == 12'h000 |-> prdata_out[7] == !busy_out)
    else $error("complete flag disagrees with busy");
  busy_cause_a: assert property ($rose(busy_out) |-> $past(lnch))
    else $error("busy without launch");
  secure_fall_a: assert property ($fell(secure_out) |-> $past(busy_out) || $past(busy_out, 2))
    else $error("security released without erase");
endmodule
bind feu_core feu_props feu_props_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .busy_out(busy_out), .secure_out(secure_out));

// ### feu_core_test.sv
/* self-checking bench for feu_core.
   assumes the apb slave and timing of feu_regs.vh. */
`include "feu_regs.vh"
module feu_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] blk = `FEU_CMD_BLK;
  localparam logic [7:0] sec = `FEU_CMD_SEC;
  localparam logic [7:0] uns = `FEU_CMD_UNS;
  localparam logic [7:0] pf = `FEU_PF_HI;
  localparam logic [7:0] ee = `FEU_EE_HI;
  logic clk_in, arst_n_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd, rnd;
  logic pready_out, pslverr_out, busy_out, secure_out, er, sec_exp;
  integer errors, checked, cyc;
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  feu_core feu_core_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .busy_out(busy_out), .secure_out(secure_out));
  // ==========
  // report and compare
  task summarize;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // hang guard, runs far past the longest sequence
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      summarize;
    end
  end
  // ==========
  // apb master: waits for ready, no fixed latency
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  function automatic logic [15:0] rn();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[15:0] & 16'hfff8;
  endfunction
  // ==========
  // expected status word for one launch
  function automatic logic [31:0] model(input logic [7:0] c, input logic [2:0] ix,
    input logic [7:0] hi, input logic [15:0] lo, input logic [2:0] m, p, input logic [1:0] f);
    logic acc, pv, ok;
    acc = 1'b1;
    pv = 1'b0;
    if (c == blk) begin
      acc = ix != 1 || !m[0] || !(hi == pf || hi == ee) || (hi == pf ? lo[2:0] != 0 : lo[0]);
      pv = hi == pf ? |p[1:0] : p[2];
    end
    if (c == sec) begin
      acc = ix != 1 || !m[1] || hi != pf || lo[2:0] != 0;
      pv = p[1] || (p[0] && lo[15:9] == 0);
    end
    if (c == uns) begin
      acc = ix != 0 || !m[2];
      pv = |p;
    end
    pv = pv & !acc;
    ok = !acc && !pv;
    return {24'h0, 2'b10, acc, pv, 2'b00, ok && |f, ok && f[1]};
  endfunction
  task run(input logic [7:0] c, input logic [2:0] ix, input logic [7:0] hi,
    input logic [15:0] lo, input logic [2:0] m, p, input logic [1:0] f);
    logic [31:0] e;
    integer n;
    e = model(c, ix, hi, lo, m, p, f);
    apb(1'b1, `FEU_OFF_MODE, {29'h0, m});
    apb(1'b1, `FEU_OFF_PROT, {29'h0, p});
    apb(1'b1, `FEU_OFF_FAULT, {30'h0, f});
    apb(1'b1, `FEU_OFF_INDEX, 32'h0);
    apb(1'b1, `FEU_OFF_PARAM, {16'h0, c, hi});
    apb(1'b1, `FEU_OFF_INDEX, 32'h1);
    apb(1'b1, `FEU_OFF_PARAM, {16'h0, lo});
    apb(1'b0, `FEU_OFF_PARAM, 32'h0);
    chk("param word", {16'h0, lo}, rd);
    apb(1'b1, `FEU_OFF_INDEX, {29'h0, ix});
    apb(1'b1, `FEU_OFF_STAT, 32'h80);
    repeat (3) @(posedge clk_in);
    chk("busy", {31'h0, e[5:4] == 2'b00}, {31'h0, busy_out});
    n = 0;
    // no register writes until the command has finished
    while (busy_out === 1'b1) begin
      @(posedge clk_in);
      n = n + 1;
    end
    if (e[5:4] == 2'b00)
      chk("long", 32'h1, {31'h0, n + 3 >= `FEU_ERASE_CYC + `FEU_VERIFY_CYC});
    if (e[5:4] == 2'b00)
      chk("late", 32'h1, {31'h0, n + 3 <= `FEU_ERASE_CYC + `FEU_VERIFY_CYC + 4});
    if (c == uns && e[5:4] == 2'b00 && f == 2'b00)
      sec_exp = 1'b0;
    apb(1'b0, `FEU_OFF_STAT, 32'h0);
    chk("status", e, rd);
    chk("secure", {31'h0, sec_exp}, {31'h0, secure_out});
    $display("command %h ix %0d done", c, ix);
  endtask
  // ==========
  // main sequence
  initial begin
    {psel_in, penable_in, pwrite_in, arst_n_in} = 4'h0;
    paddr_in = 12'h0;
    pwdata_in = 32'h0;
    {errors, checked, cyc} = {32'd0, 32'd0, 32'd0};
    rnd = 32'habe30399;
    sec_exp = 1'b1;
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    apb(1'b0, `FEU_OFF_STAT, 32'h0);
    chk("stat reset", 32'h80, rd);
    apb(1'b0, `FEU_OFF_MODE, 32'h0);
    chk("mode reset", {29'h0, `FEU_MODE_RST}, rd);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    run(blk, 1, pf, rn(), 7, 0, 0);
    run(blk, 1, ee, rn() | 16'h0006, 7, 2, 0);
    run(blk, 0, pf, 0, 7, 0, 0);
    run(sec, 2, pf, 0, 7, 0, 0);
    run(blk, 1, pf, 0, 6, 0, 0);
    run(sec, 1, pf, 0, 5, 0, 0);
    run(uns, 0, pf, 0, 3, 0, 0);
    run(blk, 1, 8'h55, 0, 7, 0, 0);
    run(sec, 1, ee, 0, 7, 0, 0);
    run(blk, 1, pf, 16'h0004, 7, 0, 0);
    run(blk, 1, ee, 16'h0003, 7, 0, 0);
    run(blk, 1, pf, 0, 7, 1, 0);
    run(blk, 1, ee, 0, 7, 4, 0);
    run(blk, 1, pf, 0, 7, 0, 1);
    run(sec, 1, pf, 16'h0200, 7, 0, 3);
    run(sec, 1, pf, rn(), 7, 0, 0);
    run(sec, 1, pf, 16'h0401, 7, 0, 0);
    run(sec, 1, pf, 16'h01f8, 7, 1, 0);
    run(sec, 1, pf, 16'h0200, 7, 1, 0);
    run(sec, 1, pf, 16'h0400, 7, 2, 0);
    run(uns, 1, pf, 0, 7, 0, 0);
    run(uns, 0, pf, 0, 7, 4, 0);
    run(uns, 0, pf, 0, 7, 0, 1);
    run(uns, 0, pf, 0, 7, 0, 0);
    apb(1'b1, `FEU_OFF_SEC, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("secure set", 32'h1, {31'h0, secure_out});
    apb(1'b1, `FEU_OFF_SEC, 32'h0);
    repeat (2) @(posedge clk_in);
    chk("secure kept", 32'h1, {31'h0, secure_out});
    summarize;
  end
endmodule

// ### feu_param_mem.v
/*
 * small parameter word store: eight 16-bit command parameter words,
 * registered read data. assumes a single clock and synchronous writes.
 */
module feu_param_mem (
  input  wire        clk_in,     // clock
  input  wire        wr_en_in,   // write strobe
  input  wire [2:0]  wr_idx_in,  // write index
  input  wire [15:0] wr_dat_in,  // write data
  input  wire [2:0]  rd_idx_in,  // read index
  output reg  [15:0] rd_dat_out  // registered read data
);
  reg [15:0] mem_q [0:7];

  // ================================================================
  // storage and registered read port
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_idx_in] <= wr_dat_in;
    end
    rd_dat_out <= mem_q[rd_idx_in];
  end
endmodule

// ### feu_regs.vh
/*
 * register map, field positions, command codes and timing counts for the
 * erase / unsecure command sequencer. assumes inclusion by bare name.
 */
`ifndef FEU_REGS_VH
`define FEU_REGS_VH

// ==================================================================
// register byte offsets
`define FEU_OFF_STAT      12'h000
`define FEU_OFF_INDEX     12'h004
`define FEU_OFF_PARAM     12'h008
`define FEU_OFF_MODE      12'h00c
`define FEU_OFF_PROT      12'h010
`define FEU_OFF_SEC       12'h014
`define FEU_OFF_FAULT     12'h018

// ==================================================================
// status register fields
`define FEU_STAT_DONE_BIT 7
`define FEU_STAT_ACC_BIT  5
`define FEU_STAT_PV_BIT   4
`define FEU_STAT_VE_BIT   1
`define FEU_STAT_VF_BIT   0

// ==================================================================
// command codes
`define FEU_CMD_BLK       8'h09
`define FEU_CMD_SEC       8'h0a
`define FEU_CMD_UNS       8'h0b

// ==================================================================
// expected parameter index at launch
`define FEU_IX_BLK        3'h1
`define FEU_IX_UNS        3'h0

// ==================================================================
// address map: program block and data block high bytes
`define FEU_PF_HI         8'h00
`define FEU_EE_HI         8'h10
`define FEU_SECT_BITS     9

// ==================================================================
// mode enable bits, protection bits, reset values
`define FEU_MODE_RST      3'h7
`define FEU_PROT_RST      3'h0
`define FEU_SEC_RST       1'h1

// ==================================================================
// erase and verify timing: 20 us erase, 5 us verify at 100 ns clock
`define FEU_ERASE_NS      20000
`define FEU_VERIFY_NS     5000
`define FEU_CLK_NS        100
`define FEU_ERASE_CYC     ((`FEU_ERASE_NS + `FEU_CLK_NS - 1) / `FEU_CLK_NS)
`define FEU_VERIFY_CYC    ((`FEU_VERIFY_NS + `FEU_CLK_NS - 1) / `FEU_CLK_NS)

`endif
